/* File: src/serial_irq_line_pkg.sv */
// Purpose: Shared constants and types for the serial interrupt line host.
// Assumes: One 40 MHz clock; the line is sampled as a synchronous input.
// Notes: Frame positions count from 1, as the peripherals count them.
`default_nettype none
package irq_line_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int FRAME_W = 6;
  localparam int FRAME_COUNT = 32;
  localparam int IRQ_COUNT = 16;
  localparam int PCI_INT_COUNT = 4;
  // Start frame: host adds 3 to 7 low clocks after the peripheral pulse.
  localparam logic [2:0] START_EXTRA_MIN = 3'h3;
  localparam logic [2:0] START_EXTRA_RESET = 3'h3;
  // Stop frame low time selects the next mode.
  localparam logic [2:0] STOP_QUIET_CLKS = 3'h2;
  localparam logic [2:0] STOP_CONT_CLKS = 3'h3;
  // Clocks after the stop rising edge before a new start may begin.
  localparam logic [2:0] STOP_GAP_CLKS = 3'h2;
  localparam logic MODE_QUIET_RESET = 1'b0;
  // Phase codes inside a three-clock data frame.
  localparam logic [1:0] PH_SAMPLE = 2'h0;
  localparam logic [1:0] PH_RECOVER = 2'h1;
  localparam logic [1:0] PH_TURN = 2'h2;
  // Fixed slot usage.
  localparam int FRAME_MGMT = 3;
  localparam int FRAME_IOCHK = 17;
  localparam int FRAME_PCI_FIRST = 18;
  localparam int FRAME_PCI_LAST = 21;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_START_LOW = 6'h02,
    ST_START_HIGH = 6'h04,
    ST_DATA = 6'h08,
    ST_STOP_LOW = 6'h10,
    ST_STOP_GAP = 6'h20
  } state_t;

  typedef struct packed {
    logic [IRQ_COUNT-1:0] irq;
    logic mgmt;
    logic io_chk;
    logic [PCI_INT_COUNT-1:0] pci_int;
  } irq_status_t;

  typedef struct packed {
    logic [2:0] start_extra;
    logic quiet_next;
  } link_cfg_t;

  // True for ISA request numbers that own a data frame (frame = number + 1).
  function automatic logic irq_has_slot(input int k);
    return (k == 1) || (k >= 3 && k <= 7) || (k >= 9 && k <= 12) || (k == 14) || (k == 15);
  endfunction
endpackage
`default_nettype wire

/* File: src/frame_slot_capture.sv */
// Purpose: Holds the level sampled in each data frame and maps it to requests.
// Assumes: sample_i is a one-cycle pulse in the Sample phase of frame_i.
// Notes: Each level stands until the same frame of the next cycle.
`timescale 1ns/1ps
`default_nettype none
module frame_slot_capture #(
  parameter int FRAMES = irq_line_pkg::FRAME_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sample_i,
  input wire logic [irq_line_pkg::FRAME_W-1:0] frame_i,
  input wire logic active_i,
  output irq_line_pkg::irq_status_t status_o
);
  import irq_line_pkg::*;

  logic [FRAMES:1] slot_reg, slot_next;
  irq_status_t status_reg, status_next;
  logic [IRQ_COUNT-1:0] irq_map;

  always_comb begin
    slot_next = slot_reg;
    if (sample_i && frame_i >= FRAME_W'(1) && frame_i <= FRAME_W'(FRAMES)) begin
      slot_next[frame_i] = active_i;
    end
  end

  // Unassigned slots are captured but reach no request.
  for (genvar k = 0; k < IRQ_COUNT; k++) begin : g_irq
    if (irq_has_slot(k)) begin : g_used
      assign irq_map[k] = slot_next[k+1];
    end else begin : g_none
      assign irq_map[k] = 1'b0;
    end
  end

  always_comb begin
    status_next.irq = irq_map;
    status_next.mgmt = slot_next[FRAME_MGMT];
    status_next.io_chk = slot_next[FRAME_IOCHK];
    status_next.pci_int = slot_next[FRAME_PCI_LAST:FRAME_PCI_FIRST];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_reg <= '0;
      status_reg <= '0;
    end else begin
      slot_reg <= slot_next;
      status_reg <= status_next;
    end
  end

  assign status_o = status_reg;
endmodule
`default_nettype wire

/* File: src/serial_irq_line_host.sv */
// Purpose: Host end of the shared serial interrupt line: start, sample, stop.
// Assumes: External pull-up on the line; SERIAL_IRQ_LINE_I synchronous to CLK_I.
// Notes: The line is open-drain except for the one high clock after a start.
// Operation
// - Host then drives low 3 to 7 more.
// - Then one high clock, then release.
// - Continuous mode: host starts, 4 to 8 low.
// - Reset enters continuous mode.
// - Each data frame is exactly three clocks.
// - Nobody drives in recovery or turn-around.
// - Frame n sampled 3n-1 clocks after start.
// - Slot usage is fixed per frame number.
// - Frame three active raises management interrupt output.
// - Stop frame drives low two or three clocks.
// - Two-clock stop selects quiet mode next.
// - Three-clock stop selects continuous mode next.
// - Open-drain sharing, timing on the bus clock.
`timescale 1ns/1ps
`default_nettype none
module serial_irq_host #(
  parameter int FRAMES = irq_line_pkg::FRAME_COUNT
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic SERIAL_IRQ_LINE_I,
  output logic SERIAL_IRQ_LINE_O,
  output logic SERIAL_IRQ_LINE_OE_O,
  input wire irq_line_pkg::link_cfg_t CFG_I,
  output logic QUIET_MODE_O,
  output logic EXTERNAL_MGMT_INT_OUT_O,
  output irq_line_pkg::irq_status_t IRQ_STATUS_O
);
  import irq_line_pkg::*;

  state_t state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [1:0] phase_reg, phase_next;
  logic [FRAME_W-1:0] frame_reg, frame_next;
  logic quiet_reg, quiet_next;
  logic oe_reg, oe_next;
  logic out_reg, out_next;
  logic mgmt_reg, mgmt_next;
  logic [2:0] extra;
  logic sample_pulse;
  logic line_active;
  irq_status_t status;

  // Requests below the minimum are raised to it rather than refused.
  assign extra = (CFG_I.start_extra < START_EXTRA_MIN) ? START_EXTRA_MIN : CFG_I.start_extra;
  assign sample_pulse = (state_reg == ST_DATA) && (phase_reg == PH_SAMPLE);
  assign line_active = !SERIAL_IRQ_LINE_I;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    phase_next = phase_reg;
    frame_next = frame_reg;
    quiet_next = quiet_reg;
    case (state_reg)
      ST_IDLE: begin
        if (!quiet_reg) begin
          state_next = ST_START_LOW;
          cnt_next = extra;
        end else if (line_active) begin
          // The peripheral pulse was the first low clock of the start frame.
          state_next = ST_START_LOW;
          cnt_next = 3'(extra - 3'h1);
        end
      end
      ST_START_LOW: begin
        if (cnt_reg == 3'h0) begin
          state_next = ST_START_HIGH;
        end else begin
          cnt_next = 3'(cnt_reg - 3'h1);
        end
      end
      ST_START_HIGH: begin
        // The clock after the rising edge is a turn-around before frame 1.
        state_next = ST_DATA;
        phase_next = PH_TURN;
        frame_next = '0;
      end
      ST_DATA: begin
        if (phase_reg == PH_TURN) begin
          if (frame_reg == FRAME_W'(FRAMES)) begin
            state_next = ST_STOP_LOW;
            quiet_next = CFG_I.quiet_next;
            cnt_next = CFG_I.quiet_next ? 3'(STOP_QUIET_CLKS - 3'h1)
                                        : 3'(STOP_CONT_CLKS - 3'h1);
          end else begin
            phase_next = PH_SAMPLE;
            frame_next = FRAME_W'(frame_reg + FRAME_W'(1));
          end
        end else if (phase_reg == PH_SAMPLE) begin
          phase_next = PH_RECOVER;
        end else begin
          phase_next = PH_TURN;
        end
      end
      ST_STOP_LOW: begin
        if (cnt_reg == 3'h0) begin
          state_next = ST_STOP_GAP;
          cnt_next = 3'(STOP_GAP_CLKS - 3'h1);
        end else begin
          cnt_next = 3'(cnt_reg - 3'h1);
        end
      end
      ST_STOP_GAP: begin
        // Pulses seen in the gap are too early to open a start frame.
        if (cnt_reg == 3'h0) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = 3'(cnt_reg - 3'h1);
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Drive follows the next state so the pin flops change with the state.
  always_comb begin
    oe_next = 1'b0;
    out_next = 1'b0;
    case (state_next)
      ST_START_LOW: begin
        oe_next = 1'b1;
        out_next = 1'b0;
      end
      ST_START_HIGH: begin
        oe_next = 1'b1;
        out_next = 1'b1;
      end
      ST_STOP_LOW: begin
        oe_next = 1'b1;
        out_next = 1'b0;
      end
      default: begin
        oe_next = 1'b0;
        out_next = 1'b0;
      end
    endcase
  end

  always_comb begin
    mgmt_next = mgmt_reg;
    if (sample_pulse && frame_reg == FRAME_W'(FRAME_MGMT)) begin
      mgmt_next = line_active;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
      phase_reg <= PH_TURN;
      frame_reg <= '0;
      quiet_reg <= MODE_QUIET_RESET;
      oe_reg <= 1'b0;
      out_reg <= 1'b0;
      mgmt_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
      frame_reg <= frame_next;
      quiet_reg <= quiet_next;
      oe_reg <= oe_next;
      out_reg <= out_next;
      mgmt_reg <= mgmt_next;
    end
  end

  frame_slot_capture #(
    .FRAMES(FRAMES)
  ) u_capture (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .sample_i(sample_pulse),
    .frame_i(frame_reg),
    .active_i(line_active),
    .status_o(status)
  );

  assign SERIAL_IRQ_LINE_O = out_reg;
  assign SERIAL_IRQ_LINE_OE_O = oe_reg;
  assign QUIET_MODE_O = quiet_reg;
  assign EXTERNAL_MGMT_INT_OUT_O = mgmt_reg;
  assign IRQ_STATUS_O = status;

  // Checking helpers: length of the current host low run, clocks since start edge.
  logic [3:0] low_run_reg;
  logic [7:0] since_edge_reg;
  logic [7:0] sample_clock;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      low_run_reg <= 4'h0;
      since_edge_reg <= 8'h0;
    end else begin
      low_run_reg <= (oe_reg && !out_reg) ? 4'(low_run_reg + 4'h1) : 4'h0;
      if (state_reg == ST_START_HIGH) begin
        since_edge_reg <= 8'h1;
      end else if (since_edge_reg != 8'hff) begin
        since_edge_reg <= 8'(since_edge_reg + 8'h1);
      end
    end
  end

  assign sample_clock = 8'(({2'h0, frame_reg} * 8'h3) - 8'h1);

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  reset_mode_a: assert property (disable iff (1'b0) SYS_RST_I |=> !QUIET_MODE_O && !SERIAL_IRQ_LINE_OE_O) else $error("reset did not leave continuous mode idle");
  quiet_takeover_a: assert property (state_reg == ST_IDLE && quiet_reg && line_active |=> SERIAL_IRQ_LINE_OE_O && !SERIAL_IRQ_LINE_O) else $error("host did not take over quiet start");
  quiet_start_len_a: assert property (SERIAL_IRQ_LINE_OE_O && SERIAL_IRQ_LINE_O && quiet_reg |-> low_run_reg >= 4'h3 && low_run_reg <= 4'h7) else $error("quiet start low length wrong");
  cont_start_len_a: assert property (SERIAL_IRQ_LINE_OE_O && SERIAL_IRQ_LINE_O && !quiet_reg |-> low_run_reg >= 4'h4 && low_run_reg <= 4'h8) else $error("continuous start low length wrong");
  start_release_a: assert property (SERIAL_IRQ_LINE_OE_O && SERIAL_IRQ_LINE_O |=> !SERIAL_IRQ_LINE_OE_O [*8]) else $error("line not released after start");
  sample_time_a: assert property (sample_pulse |-> since_edge_reg == sample_clock) else $error("data frame sampled at wrong clock");
  frame_period_a: assert property (sample_pulse && frame_reg < FRAME_W'(FRAMES) |-> ##3 sample_pulse && frame_reg == $past(frame_reg, 3) + FRAME_W'(1)) else $error("data frame not three clocks");
  data_quiet_a: assert property (state_reg == ST_DATA |-> !SERIAL_IRQ_LINE_OE_O) else $error("host drove line in a data frame");
  mgmt_out_a: assert property (sample_pulse && frame_reg == FRAME_W'(FRAME_MGMT) |=> EXTERNAL_MGMT_INT_OUT_O == $past(line_active)) else $error("management output not from frame 3");
  stop_len_a: assert property ($fell(SERIAL_IRQ_LINE_OE_O) && !$past(SERIAL_IRQ_LINE_O) |-> low_run_reg == (QUIET_MODE_O ? 4'h2 : 4'h3)) else $error("stop length does not match next mode");
  stop_gap_a: assert property ($fell(SERIAL_IRQ_LINE_OE_O) && !$past(SERIAL_IRQ_LINE_O) |-> !SERIAL_IRQ_LINE_OE_O [*3]) else $error("start too soon after stop");
  level_hold_a: assert property (!$past(sample_pulse) |-> $stable(IRQ_STATUS_O)) else $error("request level changed outside its frame");

  quiet_start_c: cover property (state_reg == ST_IDLE && quiet_reg && line_active);
  mgmt_seen_c: cover property ($rose(EXTERNAL_MGMT_INT_OUT_O));
  quiet_stop_c: cover property (state_reg == ST_STOP_LOW && quiet_reg);
  cont_cycle_c: cover property (state_reg == ST_STOP_GAP && !quiet_reg ##2 state_reg == ST_START_LOW);
endmodule
`default_nettype wire

/* File: sim/serial_irq_line_peer.sv */
// Purpose: Behavioural peripheral on the shared serial interrupt line.
// Assumes: Pulled-up line, resolved level seen on each rising edge.
// Notes: Only pulls low; frame count restarts at every start rising edge.
`timescale 1ns/1ps
`default_nettype none
module irq_line_peer #(
  parameter int FRAMES = 32
) (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic req_i,
  input wire logic [32:1] active_i,
  output logic pull_o,
  output logic busy_o
);
  logic prev_reg = 1'b1;
  logic [1:0] phase_reg = 2'h0;
  logic [7:0] cnt_reg = 8'h0;
  logic pulse_reg = 1'b0;
  logic done_reg = 1'b0;
  int idx;
  always @(posedge clk_i) begin
    prev_reg <= line_i;
    cnt_reg <= cnt_reg + 8'h1;
    pulse_reg <= 1'b0;
    if (phase_reg != 2'h1 && !prev_reg && line_i) begin
      phase_reg <= (phase_reg == 2'h0) ? 2'h1 : 2'h0;
      cnt_reg <= 8'h1;
    end else if (phase_reg == 2'h1 && cnt_reg == 8'(3 * FRAMES + 1)) begin
      phase_reg <= 2'h2;
    end
    if (phase_reg == 2'h1) begin
      done_reg <= 1'b0;
    end else if (phase_reg == 2'h0 && cnt_reg >= 8'h3 && req_i && !done_reg && line_i) begin
      pulse_reg <= 1'b1;
      done_reg <= 1'b1;
    end
  end
  // The slot is driven for the whole Sample clock and released otherwise.
  assign idx = (int'(cnt_reg) + 1) / 3;
  assign pull_o = pulse_reg | (phase_reg == 2'h1 && cnt_reg % 3 == 2 && idx <= FRAMES
    && active_i[idx]);
  assign busy_o = phase_reg != 2'h0;
endmodule
`default_nettype wire

/* File: sim/serial_irq_line_host_test.sv */
// Purpose: Self-checking bench for the serial interrupt line host.
// Assumes: Line low runs are measured on the resolved wire each falling edge.
// Notes: Random slot masks from a fixed seed; corner masks mixed in.
`timescale 1ns/1ps
`default_nettype none
module serial_irq_host_test;
  import irq_line_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic host_o, host_oe, quiet, mgmt, busy, pull;
  link_cfg_t cfg = '{start_extra: 3'h3, quiet_next: 1'b0};
  irq_status_t status;
  logic [32:1] mask = '0;
  // Wired low: a peripheral pull wins over the host and the pull-up alike.
  wire logic line = (host_oe ? host_o : 1'b1) & !pull;
  int fail_count = 0;
  int n_tests = 0;
  int seed = 4122;
  int cycles = 0;
  int low_run = 0;
  int runs[$];

  serial_irq_host u_serial_irq_host (
    .CLK_I(clk), .SYS_RST_I(rst), .SERIAL_IRQ_LINE_I(line), .SERIAL_IRQ_LINE_O(host_o),
    .SERIAL_IRQ_LINE_OE_O(host_oe), .CFG_I(cfg), .QUIET_MODE_O(quiet),
    .EXTERNAL_MGMT_INT_OUT_O(mgmt), .IRQ_STATUS_O(status));
  irq_line_peer u_irq_line_peer (
    .clk_i(clk), .line_i(line), .req_i(req), .active_i(mask), .pull_o(pull), .busy_o(busy));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A hang in the handshake ends the run through the same report.
  always @(negedge clk) begin
    cycles++;
    if (line === 1'b0) begin
      low_run++;
    end else if (low_run > 0) begin
      runs.push_back(low_run);
      low_run = 0;
    end
    if (cycles > 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic irq_status_t want(logic [32:1] m);
    irq_status_t s;
    s = '0;
    for (int k = 0; k < 16; k++) begin
      if (k == 1 || (k >= 3 && k != 8 && k != 13)) s.irq[k] = m[k + 1];
    end
    s.mgmt = m[3];
    s.io_chk = m[17];
    s.pci_int = m[21:18];
    return s;
  endfunction

  function automatic int next_run();
    return runs.size() > 0 ? runs.pop_front() : 0;
  endfunction

  task automatic wait_busy(logic lvl);
    int t;
    t = 0;
    while (busy !== lvl && t < 400) begin
      @(negedge clk);
      t++;
    end
    check("busy", lvl, busy);
  endtask

  task automatic run_cycle(logic [2:0] extra, logic qnext, logic pulse, logic [32:1] m);
    int e;
    mask = m;
    if (pulse) begin
      cfg.start_extra = extra;
      req = 1'b1;
    end
    e = (cfg.start_extra < 3) ? 4 : cfg.start_extra + 1;
    wait_busy(1'b1);
    check("released", 1'b0, host_oe);
    req = 1'b0;
    cfg.quiet_next = qnext;
    wait_busy(1'b0);
    @(negedge clk);
    check("start_run", e, next_run());
    for (int n = 1; n <= 32; n++) begin
      if (m[n]) check("data_run", 1, next_run());
    end
    check("stop_run", qnext ? 2 : 3, next_run());
    check("extra_runs", 0, runs.size());
    check("quiet_mode", qnext, quiet);
    check("status", want(m), status);
    check("mgmt_out", m[3], mgmt);
    runs.delete();
    $display("cycle done extra %0d quiet %0d", extra, qnext);
  endtask

  initial begin
    repeat (4) @(negedge clk);
    check("reset_mode", 1'b0, quiet);
    runs.delete();
    rst = 1'b0;
    run_cycle(3'h3, 1'b0, 1'b0, $random(seed));
    run_cycle(3'h3, 1'b1, 1'b0, '1);
    repeat (150) @(negedge clk);
    check("quiet_idle", 0, runs.size());
    $display("quiet idle done");
    for (int i = 0; i < 8; i++) begin
      run_cycle(i[2:0], i != 7, 1'b1, i == 0 ? 32'h0 : $random(seed));
    end
    run_cycle(3'h7, 1'b0, 1'b0, 32'h0000_0004);
    give_verdict();
  end
endmodule
`default_nettype wire
